//--- core/cksw_clock_switcher.sv
// run-time system clock source switching controller
`timescale 1ns/1ps
`default_nettype none
module cksw_clock_switcher (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [cksw_pkg::ADDR_W-1:0] regAddr,
  input wire logic [cksw_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [cksw_pkg::DATA_W-1:0] regRdata,
  input wire logic switchEnableFuse,
  input wire logic monitorDisableFuse,
  input wire logic [cksw_pkg::SRC_W-1:0] initialSourceFuse,
  input wire logic [1:0] primarySubmodeFuse,
  input wire logic watchdogEnable,
  input wire logic ostExpired,
  input wire logic pllLocked,
  input wire logic oscFail,
  input wire logic [cksw_pkg::SRC_N-1:0] srcClk,
  output logic [cksw_pkg::OSC_N-1:0] oscEnable,
  output logic pllEnable,
  output logic [cksw_pkg::SRC_W-1:0] sysClkSel,
  output logic clockFailTrap,
  output logic irq
);
  import cksw_pkg::*;

  // unlock and read-back state
  logic keyStage_r;
  logic keyStage_nxt;
  logic [2:0] unlockWin_r;
  logic [2:0] unlockWin_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic wrLo;
  logic wrHi;

  // switch control state
  cksw_state_t st_r;
  cksw_state_t st_nxt;
  logic booted_r;
  logic booted_nxt;
  logic [SRC_W-1:0] curSel_r;
  logic [SRC_W-1:0] curSel_nxt;
  logic [SRC_W-1:0] reqSel_r;
  logic [SRC_W-1:0] reqSel_nxt;
  logic [SRC_W-1:0] sysSel_r;
  logic [SRC_W-1:0] sysSel_nxt;
  logic swReq_r;
  logic swReq_nxt;
  logic lock_r;
  logic lock_nxt;
  logic cf_r;
  logic cf_nxt;
  logic keep_r;
  logic keep_nxt;
  logic [OSC_N-1:0] oscOn_r;
  logic [OSC_N-1:0] oscOn_nxt;
  logic [OSC_N-1:0] oscEn_r;
  logic [OSC_N-1:0] oscEn_nxt;
  logic pllOn_r;
  logic pllOn_nxt;
  logic trap_r;
  logic trap_nxt;
  logic evDone;
  logic evRedund;
  logic evFail;
  logic swEn;
  logic monEn;
  logic ready;
  logic cntDone;
  logic [SRC_W-1:0] failSel;
  logic [OSC_N-1:0] keepMask;

  // interrupt state
  logic [IRQ_N-1:0] irqStat_r;
  logic [IRQ_N-1:0] irqStat_nxt;
  logic [IRQ_N-1:0] irqMask_r;
  logic [IRQ_N-1:0] irqMask_nxt;

  assign swEn = !switchEnableFuse;
  assign monEn = swEn && !monitorDisableFuse;
  assign wrLo = regWr && regAddr == ADDR_CTRL_LO && unlockWin_r != 3'h0;
  assign wrHi = regWr && regAddr == ADDR_CTRL_HI && unlockWin_r != 3'h0;

  // the unlock is spent by the next write of any kind, so a stray
  // write between key and control byte cancels it
  always_comb begin
    keyStage_nxt = keyStage_r;
    unlockWin_nxt = unlockWin_r;
    if (regWr) begin
      unlockWin_nxt = 3'h0;
      keyStage_nxt = 1'b0;
      if (regAddr == ADDR_UNLOCK) begin
        if (keyStage_r && regWdata == UNLOCK_KEY2) begin
          unlockWin_nxt = UNLOCK_WIN;
        end else begin
          keyStage_nxt = regWdata == UNLOCK_KEY1;
        end
      end
    end else if (unlockWin_r != 3'h0) begin
      unlockWin_nxt = unlockWin_r - 3'h1;
    end
  end

  // reads answer on the next edge; the switch never holds the port
  always_comb begin
    rdata_nxt = 16'h0000;
    if (regRd) begin
      unique case (regAddr)
        ADDR_CTRL_LO, ADDR_CTRL_HI: begin
          rdata_nxt[CUR_LSB+:SRC_W] = curSel_r;
          rdata_nxt[REQ_LSB+:SRC_W] = reqSel_r;
          rdata_nxt[LOCK_BIT] = lock_r;
          rdata_nxt[CF_BIT] = cf_r;
          rdata_nxt[KEEP_BIT] = keep_r;
          rdata_nxt[SWREQ_BIT] = swReq_r;
        end
        ADDR_IRQ_STAT: rdata_nxt[IRQ_N-1:0] = irqStat_r;
        ADDR_IRQ_MASK: rdata_nxt[IRQ_N-1:0] = irqMask_r;
        ADDR_STATUS: begin
          rdata_nxt[3:0] = oscEn_r;
          rdata_nxt[4] = pllOn_r;
          rdata_nxt[5] = st_r != ST_IDLE;
          rdata_nxt[6] = swEn;
          rdata_nxt[7] = monEn;
          rdata_nxt[9:8] = primarySubmodeFuse;
        end
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      keyStage_r <= 1'b0;
      unlockWin_r <= 3'h0;
      rdata_r <= 16'h0000;
    end else begin
      keyStage_r <= keyStage_nxt;
      unlockWin_r <= unlockWin_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign regRdata = rdata_r;

  cksw_edge_count #(
    .COUNT(NEW_CLK_CYCLES)
  ) u_edge_count (
    .mclk(mclk),
    .reset(reset),
    .run(st_r == ST_COUNT),
    .srcClk(srcClk[reqSel_r]),
    .done(cntDone)
  );

  assign ready = (!isCrystal(reqSel_r, primarySubmodeFuse) || ostExpired) &&
                 (!usesPll(reqSel_r) || lock_r);
  assign failSel = usesPll(curSel_r) ? SRC_FAST_RC_WITH_PLL : SRC_FRC;

  always_comb begin
    st_nxt = st_r;
    booted_nxt = 1'b1;
    curSel_nxt = curSel_r;
    reqSel_nxt = reqSel_r;
    sysSel_nxt = sysSel_r;
    swReq_nxt = swReq_r;
    lock_nxt = lock_r;
    cf_nxt = cf_r;
    keep_nxt = keep_r;
    oscOn_nxt = oscOn_r;
    pllOn_nxt = pllOn_r;
    evDone = 1'b0;
    evRedund = 1'b0;
    evFail = 1'b0;
    keepMask = 4'h0;
    if (!booted_r) begin
      // fuses are caught on the first edge after reset release
      curSel_nxt = initialSourceFuse;
      reqSel_nxt = initialSourceFuse;
      sysSel_nxt = initialSourceFuse;
      oscOn_nxt = oscOf(initialSourceFuse);
      pllOn_nxt = usesPll(initialSourceFuse);
    end else if (!swEn) begin
      swReq_nxt = 1'b0;
      curSel_nxt = initialSourceFuse;
      sysSel_nxt = initialSourceFuse;
      if (wrLo) begin
        keep_nxt = regWdata[KEEP_BIT];
      end
      lock_nxt = pllLocked && usesPll(curSel_r);
    end else begin
      if (wrLo) begin
        keep_nxt = regWdata[KEEP_BIT];
        if (regWdata[SWREQ_BIT]) begin
          swReq_nxt = 1'b1;
        end
      end
      // requested field is frozen while a switch is under way
      if (wrHi && st_r == ST_IDLE) begin
        reqSel_nxt = regWdata[REQ_LSB+:SRC_W];
      end
      unique case (st_r)
        ST_IDLE: begin
          lock_nxt = pllLocked && usesPll(curSel_r);
          if (swReq_r) begin
            if (reqSel_r == curSel_r) begin
              swReq_nxt = 1'b0;
              evRedund = 1'b1;
            end else begin
              lock_nxt = 1'b0;
              cf_nxt = 1'b0;
              oscOn_nxt = oscOn_r | oscOf(reqSel_r);
              pllOn_nxt = pllOn_r | usesPll(reqSel_r);
              st_nxt = ST_WAIT_READY;
            end
          end
        end
        ST_WAIT_READY: begin
          if (usesPll(reqSel_r) && pllLocked) begin
            lock_nxt = 1'b1;
          end
          // primary submode enters only through the crystal
          if (ready) begin
            st_nxt = ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (cntDone) begin
            st_nxt = ST_SWAP;
          end
        end
        ST_SWAP: begin
          sysSel_nxt = reqSel_r;
          curSel_nxt = reqSel_r;
          swReq_nxt = 1'b0;
          evDone = 1'b1;
          oscOn_nxt = oscOf(reqSel_r);
          pllOn_nxt = usesPll(reqSel_r);
          st_nxt = ST_IDLE;
        end
      endcase
      if (monEn && oscFail) begin
        cf_nxt = 1'b1;
        evFail = 1'b1;
        curSel_nxt = failSel;
        reqSel_nxt = failSel;
        sysSel_nxt = failSel;
        oscOn_nxt = oscOf(failSel);
        pllOn_nxt = usesPll(failSel);
        swReq_nxt = 1'b0;
        lock_nxt = 1'b0;
        st_nxt = ST_IDLE;
      end
    end
    keepMask[OSC_LOW_POWER_RC_OSC] = watchdogEnable || monEn;
    keepMask[OSC_SEC] = keep_nxt;
    oscEn_nxt = oscOn_nxt | keepMask;
    trap_nxt = evFail;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r <= ST_IDLE;
      booted_r <= 1'b0;
      curSel_r <= SRC_FRC;
      reqSel_r <= SRC_FRC;
      sysSel_r <= SRC_FRC;
      swReq_r <= 1'b0;
      lock_r <= 1'b0;
      cf_r <= 1'b0;
      keep_r <= 1'b0;
      oscOn_r <= 4'h0;
      oscEn_r <= 4'h0;
      pllOn_r <= 1'b0;
      trap_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      booted_r <= booted_nxt;
      curSel_r <= curSel_nxt;
      reqSel_r <= reqSel_nxt;
      sysSel_r <= sysSel_nxt;
      swReq_r <= swReq_nxt;
      lock_r <= lock_nxt;
      cf_r <= cf_nxt;
      keep_r <= keep_nxt;
      oscOn_r <= oscOn_nxt;
      oscEn_r <= oscEn_nxt;
      pllOn_r <= pllOn_nxt;
      trap_r <= trap_nxt;
    end
  end

  assign oscEnable = oscEn_r;
  assign pllEnable = pllOn_r;
  assign sysClkSel = sysSel_r;
  assign clockFailTrap = trap_r;

  // set wins over a write-one clear in the same cycle
  always_comb begin
    irqStat_nxt = irqStat_r;
    irqMask_nxt = irqMask_r;
    if (regWr && regAddr == ADDR_IRQ_STAT) begin
      irqStat_nxt = irqStat_r & ~regWdata[IRQ_N-1:0];
    end
    if (regWr && regAddr == ADDR_IRQ_MASK) begin
      irqMask_nxt = regWdata[IRQ_N-1:0];
    end
    irqStat_nxt[IRQ_DONE] = irqStat_nxt[IRQ_DONE] | evDone;
    irqStat_nxt[IRQ_REDUNDANT] = irqStat_nxt[IRQ_REDUNDANT] | evRedund;
    irqStat_nxt[IRQ_FAIL] = irqStat_nxt[IRQ_FAIL] | evFail;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irqStat_r <= 3'h0;
      irqMask_r <= IRQ_MASK_RST;
    end else begin
      irqStat_r <= irqStat_nxt;
      irqMask_r <= irqMask_nxt;
    end
  end

  assign irq = |(irqStat_r & irqMask_r);

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic [7:0] countCyc_r;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      countCyc_r <= 8'h00;
    end else if (st_r == ST_COUNT) begin
      countCyc_r <= (countCyc_r == 8'hFF) ? countCyc_r : countCyc_r + 8'h01;
    end else begin
      countCyc_r <= 8'h00;
    end
  end

  req_forced_a: assert property (
    booted_r && switchEnableFuse |=> !swReq_r)
    else $error("switch request set while switching disabled");
  cur_fuse_a: assert property (
    booted_r && switchEnableFuse |=> curSel_r == $past(initialSourceFuse))
    else $error("current source differs from fuse while disabled");
  redundant_abort_a: assert property (
    st_r == ST_IDLE && swReq_r && reqSel_r == curSel_r && swEn
    |=> !swReq_r && st_r == ST_IDLE && irqStat_r[IRQ_REDUNDANT])
    else $error("redundant switch not abandoned");
  start_clears_a: assert property (
    st_r == ST_IDLE && st_nxt == ST_WAIT_READY |=> !lock_r && !cf_r)
    else $error("lock or fail flag not cleared at start");
  ost_wait_a: assert property (
    st_r == ST_WAIT_READY && !ostExpired &&
    isCrystal(reqSel_r, primarySubmodeFuse) |=> st_r != ST_COUNT)
    else $error("crystal target left wait before start-up timer");
  pll_lock_a: assert property (
    st_r == ST_COUNT && usesPll(reqSel_r) |-> lock_r)
    else $error("pll target counted without lock");
  ten_edges_a: assert property (
    st_r == ST_COUNT && st_nxt == ST_SWAP |-> countCyc_r >= 8'h13)
    else $error("changeover before ten new clock cycles");
  swap_done_a: assert property (
    st_r == ST_SWAP && !oscFail
    |=> curSel_r == $past(reqSel_r) && sysClkSel == curSel_r && !swReq_r)
    else $error("completion did not update current source");
  old_off_a: assert property (
    st_r == ST_SWAP && !oscFail && !keep_nxt && !watchdogEnable && !monEn
    |=> oscEnable == oscOf(curSel_r))
    else $error("old source left running");
  fail_move_a: assert property (
    booted_r && monEn && oscFail
    |=> cf_r && clockFailTrap &&
        sysClkSel == (usesPll($past(curSel_r)) ? SRC_FAST_RC_WITH_PLL : SRC_FRC)
        ##1 !clockFailTrap || $past(oscFail))
    else $error("clock failure not handled");
  locked_write_a: assert property (
    regWr && regAddr == ADDR_CTRL_HI && unlockWin_r == 3'h0
    |=> reqSel_r == $past(reqSel_r) || $past(oscFail))
    else $error("control write taken without unlock");

  switch_done_c: cover property (st_r == ST_SWAP);
  redundant_c: cover property (evRedund);
  fail_c: cover property (evFail);
  pll_switch_c: cover property (st_r == ST_COUNT && usesPll(reqSel_r));
endmodule
`default_nettype wire

//--- core/cksw_pkg.sv
// constants, types and helpers shared by the clock switcher
//
// Contract
// - software may pick any of six clock sources while switching is enabled
// - primary submode comes from fuses only; a switch never changes it
// - switching and fail-safe monitor run only when the enable fuse reads 0
// - when disabled, requested field is ignored; current field shows fuse
// - when disabled, switch request reads zero and writes to it do nothing
// - request equal to current source clears the request and abandons it
// - a valid switch start clears the lock and clock-fail status bits
// - target oscillator is enabled; crystal targets wait for start-up timer
// - PLL targets wait for PLL lock and lock status reading one
// - ten cycles of the new clock pass before the changeover
// - completion clears switch request and copies requested to current
// - old source turned off, except kept low-power RC and secondary
// - processor keeps running; the switch never stalls the register port
// - monitored oscillator failure traps and moves to fast RC, PLL kept
package cksw_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam int SRC_W = 3;
  localparam int SRC_N = 8;
  localparam int OSC_N = 4;
  localparam int IRQ_N = 3;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_LO = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_HI = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h5;
  localparam int CUR_LSB = 12;
  localparam int REQ_LSB = 8;
  localparam int LOCK_BIT = 5;
  localparam int CF_BIT = 3;
  localparam int KEEP_BIT = 1;
  localparam int SWREQ_BIT = 0;
  localparam logic [DATA_W-1:0] UNLOCK_KEY1 = 16'h00A5;
  localparam logic [DATA_W-1:0] UNLOCK_KEY2 = 16'h005A;
  localparam logic [2:0] UNLOCK_WIN = 3'h4;
  localparam int NEW_CLK_CYCLES = 10;
  localparam logic [SRC_W-1:0] SRC_FRC = 3'h0;
  localparam logic [SRC_W-1:0] SRC_FAST_RC_WITH_PLL = 3'h1;
  localparam logic [SRC_W-1:0] SRC_PRI = 3'h2;
  localparam logic [SRC_W-1:0] SRC_PRIPLL = 3'h3;
  localparam logic [SRC_W-1:0] SRC_SEC = 3'h4;
  localparam logic [SRC_W-1:0] SRC_LOW_POWER_RC_OSC = 3'h5;
  localparam int OSC_PRI = 0;
  localparam int OSC_SEC = 1;
  localparam int OSC_FRC = 2;
  localparam int OSC_LOW_POWER_RC_OSC = 3;
  localparam logic [1:0] SUB_EC = 2'h0;
  localparam logic [1:0] SUB_XT = 2'h1;
  localparam logic [1:0] SUB_HS = 2'h2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REDUNDANT = 1;
  localparam int IRQ_FAIL = 2;
  localparam logic [IRQ_N-1:0] IRQ_MASK_RST = 3'h0;

  typedef enum {ST_IDLE, ST_WAIT_READY, ST_COUNT, ST_SWAP} cksw_state_t;

  function automatic logic usesPll(input logic [SRC_W-1:0] src);
    return (src == SRC_FAST_RC_WITH_PLL) || (src == SRC_PRIPLL);
  endfunction

  function automatic logic [OSC_N-1:0] oscOf(input logic [SRC_W-1:0] src);
    logic [OSC_N-1:0] m;
    m = 4'h0;
    unique case (src)
      SRC_FRC, SRC_FAST_RC_WITH_PLL: m[OSC_FRC] = 1'b1;
      SRC_PRI, SRC_PRIPLL: m[OSC_PRI] = 1'b1;
      SRC_SEC: m[OSC_SEC] = 1'b1;
      SRC_LOW_POWER_RC_OSC: m[OSC_LOW_POWER_RC_OSC] = 1'b1;
      default: m = 4'h0;
    endcase
    return m;
  endfunction

  // secondary is a low-power crystal; primary only in xt or hs submode
  function automatic logic isCrystal(input logic [SRC_W-1:0] src,
                                     input logic [1:0] sub);
    return (src == SRC_SEC) ||
           (((src == SRC_PRI) || (src == SRC_PRIPLL)) &&
            ((sub == SUB_XT) || (sub == SUB_HS)));
  endfunction
endpackage

//--- core/cksw_edge_count.sv
// counts rising edges of a slow source clock sampled on mclk
`timescale 1ns/1ps
`default_nettype none
module cksw_edge_count #(
  parameter int COUNT = cksw_pkg::NEW_CLK_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic run,
  input wire logic srcClk,
  output logic done
);
  import cksw_pkg::*;
  localparam int CNT_W = $clog2(COUNT + 1);
  localparam logic [CNT_W-1:0] CNT_END = CNT_W'(COUNT);

  logic sync0_r;
  logic sync1_r;
  logic prev_r;
  logic [CNT_W-1:0] cnt_r;
  logic done_r;
  logic prev_nxt;
  logic [CNT_W-1:0] cnt_nxt;
  logic done_nxt;

  // source must run below mclk/2 or edges are missed
  always_comb begin
    prev_nxt = sync1_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (!run) begin
      cnt_nxt = '0;
    end else if (cnt_r == CNT_END) begin
      done_nxt = 1'b1;
    end else if (sync1_r && !prev_r) begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync0_r <= 1'b0;
      sync1_r <= 1'b0;
      prev_r <= 1'b0;
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      sync0_r <= srcClk;
      sync1_r <= sync0_r;
      prev_r <= prev_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;

  cnt_bound_a: assert property (@(posedge mclk) disable iff (reset)
    done |-> $past(cnt_r) == CNT_END)
    else $error("done without full edge count");
endmodule
`default_nettype wire

//--- tb/cksw_osc_model.sv
// behavioural oscillators, start-up timer and pll for the clock switcher
`timescale 1ns/1ps
`default_nettype none
module cksw_osc_model #(
  parameter int OST_CYC = 8,
  parameter int LOCK_CYC = 6,
  parameter int HALF = 3
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [cksw_pkg::OSC_N-1:0] oscEnable,
  input wire logic pllEnable,
  output logic [cksw_pkg::SRC_N-1:0] srcClk,
  output logic ostExpired,
  output logic pllLocked
);
  import cksw_pkg::*;
  int ostCnt[2];
  int lockCnt;
  int divCnt;
  logic [OSC_N-1:0] oscClk;
  // codes 6 and 7 have no oscillator behind them, so they stay low
  assign srcClk = {2'h0, oscClk[OSC_LOW_POWER_RC_OSC], oscClk[OSC_SEC],
                   {2{oscClk[OSC_PRI]}}, {2{oscClk[OSC_FRC]}}};
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ostCnt <= '{0, 0};
      lockCnt <= 0;
      divCnt <= 0;
      oscClk <= '0;
      ostExpired <= 1'h0;
      pllLocked <= 1'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        ostCnt[i] <= oscEnable[i] ? ostCnt[i] + 1 : 0;
      end
      // each enabled crystal must have run its full start-up time
      ostExpired <= (oscEnable[0] | oscEnable[1]) &&
                    (!oscEnable[0] || ostCnt[0] >= OST_CYC) &&
                    (!oscEnable[1] || ostCnt[1] >= OST_CYC);
      lockCnt <= pllEnable ? lockCnt + 1 : 0;
      pllLocked <= pllEnable && lockCnt >= LOCK_CYC;
      divCnt <= (divCnt == HALF - 1) ? 0 : divCnt + 1;
      // a stopped oscillator drops low instead of freezing mid-level
      if (divCnt == HALF - 1) begin
        oscClk <= ~oscClk & oscEnable;
      end else begin
        oscClk <= oscClk & oscEnable;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_system_clock_switcher.sv
// self-checking bench for the clock switcher
`timescale 1ns/1ps
`default_nettype none
module tb_system_clock_switcher;
  import cksw_pkg::*;
  typedef struct {
    logic [SRC_W-1:0] tgt;
    logic [OSC_N-1:0] osc;
    logic pll;
    logic [IRQ_N-1:0] stat;
  } cksw_row_t;
  logic mclk, reset, regWr, regRd, swDis, monDis, wdog, oscFail, keepBit;
  logic pllEnable, pllLocked, ostExpired, clockFailTrap, irq;
  logic [ADDR_W-1:0] regAddr;
  logic [1:0] subFuse;
  logic [DATA_W-1:0] regWdata, regRdata, rdv;
  logic [SRC_W-1:0] initSrc, sysClkSel;
  logic [SRC_N-1:0] srcClk;
  logic [OSC_N-1:0] oscEnable;
  int n_errors = 0;
  int tests_run = 0;
  // plain fast rc sits between the two pll modes on purpose
  cksw_row_t rows[8] = '{
    '{SRC_PRI, 4'h1, 1'h0, 3'h1},
    '{SRC_PRIPLL, 4'h1, 1'h1, 3'h1},
    '{SRC_FRC, 4'h4, 1'h0, 3'h1},
    '{SRC_FAST_RC_WITH_PLL, 4'h4, 1'h1, 3'h1},
    '{SRC_SEC, 4'h2, 1'h0, 3'h1},
    '{SRC_LOW_POWER_RC_OSC, 4'h8, 1'h0, 3'h1},
    '{SRC_FRC, 4'h4, 1'h0, 3'h1},
    '{SRC_FRC, 4'h4, 1'h0, 3'h2}
  };

  cksw_clock_switcher i_dut (.mclk(mclk), .reset(reset), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .switchEnableFuse(swDis), .monitorDisableFuse(monDis),
    .initialSourceFuse(initSrc), .primarySubmodeFuse(subFuse),
    .watchdogEnable(wdog), .ostExpired(ostExpired), .pllLocked(pllLocked),
    .oscFail(oscFail), .srcClk(srcClk), .oscEnable(oscEnable),
    .pllEnable(pllEnable), .sysClkSel(sysClkSel),
    .clockFailTrap(clockFailTrap), .irq(irq));
  cksw_osc_model i_osc (.mclk(mclk), .reset(reset), .oscEnable(oscEnable),
    .pllEnable(pllEnable), .srcClk(srcClk), .ostExpired(ostExpired),
    .pllLocked(pllLocked));

  task automatic test_done();
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [DATA_W-1:0] got,
                       input logic [DATA_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge mclk);
    regWr <= 1'h0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge mclk);
    regRd <= 1'h0;
    #1;
    rdv = regRdata;
  endtask

  // every control byte write spends its own unlock
  task automatic ctl(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    wr(ADDR_UNLOCK, UNLOCK_KEY1);
    wr(ADDR_UNLOCK, UNLOCK_KEY2);
    wr(a, d);
  endtask

  task automatic switchTo(input logic [SRC_W-1:0] tgt);
    ctl(ADDR_CTRL_HI, {5'h0, tgt, 8'h0});
    ctl(ADDR_CTRL_LO, {14'h0, keepBit, 1'h1});
    for (int i = 0; i < 200; i++) begin
      rd(ADDR_CTRL_LO);
      if (rdv[SWREQ_BIT] === 1'h0) break;
    end
    repeat (2) @(posedge mclk);
    #1;
  endtask

  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  // the whole run needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    test_done();
  end

  initial begin
    reset = 1'h1;
    regWr = 1'h0;
    regRd = 1'h0;
    regAddr = '0;
    regWdata = '0;
    swDis = 1'h0;
    monDis = 1'h1;
    wdog = 1'h0;
    oscFail = 1'h0;
    keepBit = 1'h0;
    initSrc = SRC_FRC;
    subFuse = SUB_XT;
    repeat (2) @(posedge mclk);
    reset <= 1'h0;
    repeat (2) @(posedge mclk);
    rd(ADDR_CTRL_LO);
    check(rdv, 16'h0000);
    wr(ADDR_CTRL_HI, 16'h0200);
    rd(ADDR_CTRL_LO);
    check(rdv, 16'h0000);
    rd(3'h7);
    check(rdv, 16'h0000);
    wr(ADDR_IRQ_MASK, 16'h0007);
    foreach (rows[k]) begin
      switchTo(rows[k].tgt);
      check({13'h0, sysClkSel}, {13'h0, rows[k].tgt});
      check({12'h0, oscEnable}, {12'h0, rows[k].osc});
      check({15'h0, pllEnable}, {15'h0, rows[k].pll});
      check({15'h0, irq}, 16'h0001);
      rd(ADDR_CTRL_LO);
      check(rdv & 16'h7701, {1'h0, rows[k].tgt, 1'h0, rows[k].tgt, 8'h0});
      rd(ADDR_IRQ_STAT);
      check(rdv, {13'h0, rows[k].stat});
      wr(ADDR_IRQ_STAT, 16'h0007);
      #1;
      check({15'h0, irq}, 16'h0000);
    end
    // masked event stays quiet until its mask bit opens
    wr(ADDR_IRQ_MASK, 16'h0000);
    switchTo(SRC_FRC);
    check({15'h0, irq}, 16'h0000);
    wr(ADDR_IRQ_MASK, 16'h0002);
    #1;
    check({15'h0, irq}, 16'h0001);
    wr(ADDR_IRQ_STAT, 16'h0002);
    #1;
    check({15'h0, irq}, 16'h0000);
    @(posedge mclk);
    wdog <= 1'h1;
    keepBit = 1'h1;
    switchTo(SRC_SEC);
    check({12'h0, oscEnable}, 16'h000A);
    switchTo(SRC_FRC);
    check({12'h0, oscEnable}, 16'h000E);
    switchTo(SRC_PRIPLL);
    @(posedge mclk);
    monDis <= 1'h0;
    @(posedge mclk);
    oscFail <= 1'h1;
    @(posedge mclk);
    oscFail <= 1'h0;
    #1;
    check({15'h0, clockFailTrap}, 16'h0001);
    check({13'h0, sysClkSel}, {13'h0, SRC_FAST_RC_WITH_PLL});
    @(posedge mclk);
    #1;
    check({15'h0, clockFailTrap}, 16'h0000);
    rd(ADDR_CTRL_LO);
    check({15'h0, rdv[CF_BIT]}, 16'h0001);
    switchTo(SRC_FRC);
    rd(ADDR_CTRL_LO);
    check({15'h0, rdv[CF_BIT]}, 16'h0000);
    // second reset with switching turned off by the fuse
    @(posedge mclk);
    swDis <= 1'h1;
    initSrc <= SRC_SEC;
    subFuse <= SUB_HS;
    reset <= 1'h1;
    repeat (2) @(posedge mclk);
    reset <= 1'h0;
    repeat (2) @(posedge mclk);
    #1;
    check({13'h0, sysClkSel}, {13'h0, SRC_SEC});
    switchTo(SRC_PRI);
    repeat (80) @(posedge mclk);
    #1;
    check({13'h0, sysClkSel}, {13'h0, SRC_SEC});
    rd(ADDR_CTRL_LO);
    check(rdv & 16'h7001, {1'h0, SRC_SEC, 12'h0});
    rd(ADDR_STATUS);
    check(rdv & 16'h0340, 16'h0200);
    @(posedge mclk);
    oscFail <= 1'h1;
    @(posedge mclk);
    oscFail <= 1'h0;
    #1;
    check({15'h0, clockFailTrap}, 16'h0000);
    test_done();
  end
endmodule
`default_nettype wire
